// ### hdl/pms_pkg.sv
// Overview of operation
// - idle stops cpu and memory clocks, peripherals clocked; any interrupt returns to active.
// - wake latency to cpu active is 14 us idle, 151 us standby, 1015 us off.
// - standby powers only always-on and sensor domains; pin, rtc or sensor event wakes it.
// - standby exit resumes cpu in place; retained peripheral setup is kept.
// - standby entry freezes every gpio at its present level until wake.
// - shutdown removes all power, always-on and sensor too; pins hold last value.
// - in shutdown a level change on an enabled wake pin wakes as reset.
// - readable reset cause tells shutdown pin wake, reset pin and power-on apart.
// - across shutdown only latched pins and flash survive; other state is cleared.
// - reset pin wakes all modes; pin edge all but deepest off; rtc active/idle/standby.
// - rtc can wake the device from any mode where it keeps running.
// - standby brownout detector runs in recharge only; missed dip locks until reset.
// - radio reference from 24 MHz crystal, doubled internally to 48 MHz.
// - internal 48 MHz rc oscillator selectable as cpu clock instead of crystal.
// - without slow crystal, internal 32.768 kHz rc serves as slow reference.
// - slow 32 kHz clock can be routed out on a pin.
// - always-on domain stays powered in every mode except shutdown and off.
// - rtc has three compares and one capture, clocked by slow rc or crystal.
// - rtc rate compensation keeps correct tick when running from rc oscillator.
// - sensor controller runs in standby and can wake the cpu.
`default_nettype none
package pms_pkg;
  localparam int NUM_PINS = 8;
  localparam int CNT_W = 18;
  localparam int CLK_MHZ = 250;
  localparam int WAKE_IDLE_US = 14;
  localparam int WAKE_STANDBY_US = 151;
  localparam int WAKE_OFF_US = 1015;
  localparam int WAKE_IDLE_CYC = WAKE_IDLE_US * CLK_MHZ;
  localparam int WAKE_STANDBY_CYC = WAKE_STANDBY_US * CLK_MHZ;
  localparam int WAKE_OFF_CYC = WAKE_OFF_US * CLK_MHZ;
  localparam int FAST_XTAL_MHZ = 24;
  localparam int FAST_CLK_MHZ = 2 * FAST_XTAL_MHZ;
  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CAUSE = 8'h08;
  localparam logic [7:0] OFS_WAKE_MASK = 8'h0C;
  localparam logic [7:0] OFS_RTC_CNT = 8'h10;
  localparam logic [7:0] OFS_RTC_CMP0 = 8'h14;
  localparam logic [7:0] OFS_RTC_CMP1 = 8'h18;
  localparam logic [7:0] OFS_RTC_CMP2 = 8'h1C;
  localparam logic [7:0] OFS_RTC_CAPT = 8'h20;
  localparam logic [7:0] OFS_RTC_COMP = 8'h24;
  localparam logic [7:0] OFS_RTC_CTRL = 8'h28;
  localparam int CTRL_HF_RC_BIT = 3;
  localparam int CTRL_LF_OUT_BIT = 4;
  localparam logic [2:0] REQ_IDLE = 3'h1;
  localparam logic [2:0] REQ_STANDBY = 3'h2;
  localparam logic [2:0] REQ_SHUTDOWN = 3'h3;
  localparam logic [2:0] REQ_OFF = 3'h4;
  localparam logic [2:0] CAUSE_POR = 3'h1;
  localparam logic [2:0] CAUSE_PIN = 3'h2;
  localparam logic [2:0] CAUSE_SD_WAKE = 3'h4;
  localparam logic [31:0] RTC_COMP_RESET = 32'h00010000;
  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    MODE_ACTIVE = 3'b000,
    MODE_IDLE = 3'b001,
    MODE_STANDBY = 3'b011,
    MODE_WAKE = 3'b010,
    MODE_SHUTDOWN = 3'b110,
    MODE_OFF = 3'b111,
    MODE_RESET = 3'b100
  } pms_mode_e;
  typedef struct packed {
    logic cpu_clk;
    logic mem_clk;
    logic periph_clk;
    logic main_pwr;
    logic aon_pwr;
    logic sensor_pwr;
    logic fast_osc;
    logic retain;
  } pms_power_s;
  typedef struct packed {
    logic doubler_en;
    logic fast_src_rc;
    logic slow_src_rc;
    logic slow_clk_out;
  } pms_clock_s;
endpackage
`default_nettype wire

// ### hdl/pms_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module pms_sequencer #(
  parameter int NUM_PINS = pms_pkg::NUM_PINS,
  parameter int STANDBY_WAKE_CYC = pms_pkg::WAKE_STANDBY_CYC,
  parameter int OFF_WAKE_CYC = pms_pkg::WAKE_OFF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_pending,
  input wire logic sensor_wake,
  input wire logic recharge,
  input wire logic [NUM_PINS-1:0] gpio_level,
  input wire logic [NUM_PINS-1:0] wake_pin,
  input wire logic reset_pin_n,
  input wire logic brownout,
  input wire logic slow_xtal_present,
  input wire logic slow_xtal_clk,
  input wire logic slow_rc_clk,
  input wire logic rtc_capture_pin,
  output pms_pkg::pms_power_s power,
  output pms_pkg::pms_clock_s clocks,
  output logic cpu_rst_n,
  output logic brownout_detector_en,
  output logic io_latch,
  output logic [NUM_PINS-1:0] io_hold
);
  localparam int AW = NUM_PINS + 6;
  localparam int CW = pms_pkg::CNT_W;
  localparam logic [AW-1:0] SYNC_RST = {5'h00, 1'b1, {NUM_PINS{1'b0}}};
  localparam logic [CW-1:0] LD_IDLE = CW'(pms_pkg::WAKE_IDLE_CYC - 1);
  localparam logic [CW-1:0] LD_STANDBY = CW'(STANDBY_WAKE_CYC - 1);
  localparam logic [CW-1:0] LD_OFF = CW'(OFF_WAKE_CYC - 1);

  function automatic pms_pkg::pms_power_s mode_power(input pms_pkg::pms_mode_e m);
    pms_pkg::pms_power_s p;
    p = '0;
    case (m)
      pms_pkg::MODE_ACTIVE: p = 8'b11111110;
      pms_pkg::MODE_IDLE: p = 8'b00111110;
      pms_pkg::MODE_WAKE: p = 8'b00011111;
      pms_pkg::MODE_STANDBY: p = 8'b00001101;
      pms_pkg::MODE_RESET: p = 8'b00011110;
      default: p = 8'b00000000;
    endcase
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and filter
  logic [AW-1:0] s1_q, s2_q, s3_q, filt_q, prev_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
      s3_q <= SYNC_RST;
      filt_q <= SYNC_RST;
      prev_q <= SYNC_RST;
    end else begin
      s1_q <= {rtc_capture_pin, slow_rc_clk, slow_xtal_clk, slow_xtal_present, brownout,
               reset_pin_n, wake_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
      prev_q <= filt_q;
    end
  end

  pms_pkg::pms_mode_e mode_q, mode_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [NUM_PINS-1:0] wake_mask_q, pin_chg;
  logic rst_pin_n_f, brown_f, lf_src_rc_q, lf_now, lf_rise, capt_rise;
  assign rst_pin_n_f = filt_q[NUM_PINS];
  assign brown_f = filt_q[NUM_PINS+1];
  assign pin_chg = (filt_q[NUM_PINS-1:0] ^ prev_q[NUM_PINS-1:0]) & wake_mask_q;
  assign lf_now = lf_src_rc_q ? filt_q[NUM_PINS+4] : filt_q[NUM_PINS+3];
  assign lf_rise = lf_now & ~(lf_src_rc_q ? prev_q[NUM_PINS+4] : prev_q[NUM_PINS+3]);
  assign capt_rise = filt_q[NUM_PINS+5] & ~prev_q[NUM_PINS+5];

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave
  logic pready_q, wr_en, setup, rst_entry;
  logic [31:0] rd_val;
  logic rd_ok;
  logic [2:0] cause_q, rtc_en_q;
  logic hf_rc_q, lf_out_en_q, bod_lock_q, rtc_evt_q;
  logic [31:0] rtc_cnt_q, rtc_capt_q, rtc_comp_q, cnt_nx;
  logic [31:0] cmp_q [3];
  logic [15:0] frac_q, frac_nx;
  logic carry;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready_q;

  always_comb begin
    rd_ok = (paddr[31:8] == 24'h000000);
    rd_val = 32'h00000000;
    case (paddr[7:0])
      pms_pkg::OFS_CTRL: rd_val = {27'h0, lf_out_en_q, hf_rc_q, 3'h0};
      pms_pkg::OFS_STATUS: rd_val = {27'h0, lf_src_rc_q, bod_lock_q, mode_q};
      pms_pkg::OFS_CAUSE: rd_val = {29'h0, cause_q};
      pms_pkg::OFS_WAKE_MASK: rd_val = 32'(wake_mask_q);
      pms_pkg::OFS_RTC_CNT: rd_val = rtc_cnt_q;
      pms_pkg::OFS_RTC_CMP0: rd_val = cmp_q[0];
      pms_pkg::OFS_RTC_CMP1: rd_val = cmp_q[1];
      pms_pkg::OFS_RTC_CMP2: rd_val = cmp_q[2];
      pms_pkg::OFS_RTC_CAPT: rd_val = rtc_capt_q;
      pms_pkg::OFS_RTC_COMP: rd_val = rtc_comp_q;
      pms_pkg::OFS_RTC_CTRL: rd_val = {29'h0, rtc_en_q};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // mode sequencer
  always_comb begin
    mode_d = mode_q;
    cnt_d = (cnt_q != '0) ? cnt_q - CW'(1) : cnt_q;
    case (mode_q)
      pms_pkg::MODE_ACTIVE: begin
        if (wr_en && paddr == 32'(pms_pkg::OFS_CTRL)) begin
          case (pwdata[2:0])
            pms_pkg::REQ_IDLE: mode_d = pms_pkg::MODE_IDLE;
            pms_pkg::REQ_STANDBY: mode_d = pms_pkg::MODE_STANDBY;
            pms_pkg::REQ_SHUTDOWN: mode_d = pms_pkg::MODE_SHUTDOWN;
            pms_pkg::REQ_OFF: mode_d = pms_pkg::MODE_OFF;
            default: mode_d = pms_pkg::MODE_ACTIVE;
          endcase
        end
      end
      pms_pkg::MODE_IDLE: begin
        if (irq_pending || rtc_evt_q || sensor_wake || |pin_chg) begin
          mode_d = pms_pkg::MODE_WAKE;
          cnt_d = LD_IDLE;
        end
      end
      pms_pkg::MODE_STANDBY: begin
        if (|pin_chg || rtc_evt_q || sensor_wake) begin
          mode_d = pms_pkg::MODE_WAKE;
          cnt_d = LD_STANDBY;
        end
      end
      pms_pkg::MODE_SHUTDOWN: begin
        if (|pin_chg) begin
          mode_d = pms_pkg::MODE_RESET;
          cnt_d = LD_OFF;
        end
      end
      pms_pkg::MODE_WAKE: begin
        if (cnt_q == '0) begin
          mode_d = bod_lock_q ? pms_pkg::MODE_RESET : pms_pkg::MODE_ACTIVE;
        end
      end
      pms_pkg::MODE_RESET: begin
        if (cnt_q == '0 && !bod_lock_q) begin
          mode_d = pms_pkg::MODE_ACTIVE;
        end
      end
      pms_pkg::MODE_OFF: mode_d = pms_pkg::MODE_OFF;
      default: mode_d = pms_pkg::MODE_RESET;
    endcase
    if (!rst_pin_n_f) begin
      mode_d = pms_pkg::MODE_RESET;
      cnt_d = LD_OFF;
    end
  end
  assign rst_entry = (mode_d == pms_pkg::MODE_RESET) && (mode_q != pms_pkg::MODE_RESET);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= pms_pkg::MODE_RESET;
      cnt_q <= LD_OFF;
    end else begin
      mode_q <= mode_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= pms_pkg::CAUSE_POR;
    end else if (rst_entry) begin
      cause_q <= rst_pin_n_f ? pms_pkg::CAUSE_SD_WAKE : pms_pkg::CAUSE_PIN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software control, cleared on every reset sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_rc_q <= 1'b0;
      lf_out_en_q <= 1'b0;
      wake_mask_q <= '0;
      rtc_en_q <= 3'h0;
      rtc_comp_q <= pms_pkg::RTC_COMP_RESET;
      cmp_q <= '{default: 32'h00000000};
    end else if (rst_entry) begin
      hf_rc_q <= 1'b0;
      lf_out_en_q <= 1'b0;
      wake_mask_q <= '0;
      rtc_en_q <= 3'h0;
      rtc_comp_q <= pms_pkg::RTC_COMP_RESET;
      cmp_q <= '{default: 32'h00000000};
    end else if (wr_en && paddr[31:8] == 24'h000000) begin
      case (paddr[7:0])
        pms_pkg::OFS_CTRL: begin
          hf_rc_q <= pwdata[pms_pkg::CTRL_HF_RC_BIT];
          lf_out_en_q <= pwdata[pms_pkg::CTRL_LF_OUT_BIT];
        end
        pms_pkg::OFS_WAKE_MASK: wake_mask_q <= pwdata[NUM_PINS-1:0];
        pms_pkg::OFS_RTC_CMP0: cmp_q[0] <= pwdata;
        pms_pkg::OFS_RTC_CMP1: cmp_q[1] <= pwdata;
        pms_pkg::OFS_RTC_CMP2: cmp_q[2] <= pwdata;
        pms_pkg::OFS_RTC_COMP: rtc_comp_q <= pwdata;
        pms_pkg::OFS_RTC_CTRL: rtc_en_q <= pwdata[2:0];
        default: rtc_en_q <= rtc_en_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // real-time clock in the always-on domain
  logic rtc_run, rtc_match;
  assign rtc_run = (mode_q != pms_pkg::MODE_SHUTDOWN) && (mode_q != pms_pkg::MODE_OFF)
                   && (mode_q != pms_pkg::MODE_RESET);
  assign {carry, frac_nx} = {1'b0, frac_q} + {1'b0, rtc_comp_q[15:0]};
  assign cnt_nx = rtc_cnt_q + {16'h0000, rtc_comp_q[31:16]} + {31'h0, carry};
  always_comb begin
    rtc_match = 1'b0;
    for (int i = 0; i < 3; i++) begin
      rtc_match = rtc_match | (rtc_en_q[i] & (cnt_nx == cmp_q[i]));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_cnt_q <= 32'h00000000;
      frac_q <= 16'h0000;
      rtc_evt_q <= 1'b0;
      rtc_capt_q <= 32'h00000000;
    end else if (rst_entry) begin
      rtc_cnt_q <= 32'h00000000;
      frac_q <= 16'h0000;
      rtc_evt_q <= 1'b0;
      rtc_capt_q <= 32'h00000000;
    end else begin
      rtc_evt_q <= rtc_run & lf_rise & rtc_match;
      if (wr_en && paddr == 32'(pms_pkg::OFS_RTC_CNT)) begin
        rtc_cnt_q <= pwdata;
        frac_q <= 16'h0000;
      end else if (rtc_run && lf_rise) begin
        rtc_cnt_q <= cnt_nx;
        frac_q <= frac_nx;
      end
      if (rtc_run && capt_rise) begin
        rtc_capt_q <= rtc_cnt_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // brownout, pin latch, strap and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bod_lock_q <= 1'b0;
    end else if (mode_q == pms_pkg::MODE_STANDBY && !recharge && brown_f) begin
      bod_lock_q <= 1'b1;
    end else if (!rst_pin_n_f) begin
      bod_lock_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_latch <= 1'b0;
      io_hold <= '0;
    end else if (mode_q == pms_pkg::MODE_ACTIVE && mode_d != pms_pkg::MODE_ACTIVE
                 && mode_d != pms_pkg::MODE_IDLE && mode_d != pms_pkg::MODE_RESET) begin
      io_latch <= 1'b1;
      io_hold <= gpio_level;
    end else if (mode_d == pms_pkg::MODE_ACTIVE) begin
      io_latch <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lf_src_rc_q <= 1'b0;
    end else if (mode_q == pms_pkg::MODE_RESET) begin
      lf_src_rc_q <= ~filt_q[NUM_PINS+2];
    end
  end

  pms_pkg::pms_power_s pwr_d;
  assign pwr_d = mode_power(mode_d);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power <= 8'h1E;
      clocks <= '0;
      cpu_rst_n <= 1'b0;
      brownout_detector_en <= 1'b1;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      power <= pwr_d;
      clocks.doubler_en <= pwr_d.fast_osc;
      clocks.fast_src_rc <= pwr_d.fast_osc & hf_rc_q;
      clocks.slow_src_rc <= lf_src_rc_q;
      clocks.slow_clk_out <= lf_out_en_q & pwr_d.aon_pwr & lf_now;
      cpu_rst_n <= (mode_d != pms_pkg::MODE_RESET);
      brownout_detector_en <= (mode_d == pms_pkg::MODE_STANDBY) ? recharge : pwr_d.aon_pwr;
      prdata <= setup ? (rd_ok ? rd_val : 32'h00000000) : prdata;
      pready <= setup;
      pslverr <= setup & ~rd_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_idle_gating;
    mode_q == pms_pkg::MODE_IDLE |-> !power.cpu_clk && !power.mem_clk && power.periph_clk;
  endproperty
  a_idle_gating: assert property (p_idle_gating) else $error("idle clock gating wrong");
  property p_idle_irq;
    mode_q == pms_pkg::MODE_IDLE && irq_pending && rst_pin_n_f |=>
      mode_q == pms_pkg::MODE_WAKE && cnt_q == LD_IDLE;
  endproperty
  a_idle_irq: assert property (p_idle_irq) else $error("interrupt did not leave idle");
  property p_standby_hold;
    mode_q == pms_pkg::MODE_STANDBY && !(|pin_chg) && !rtc_evt_q && !sensor_wake
      && rst_pin_n_f |=> mode_q == pms_pkg::MODE_STANDBY;
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("standby left alone");
  property p_standby_resume;
    mode_q == pms_pkg::MODE_STANDBY && sensor_wake && rst_pin_n_f |=>
      cnt_q == LD_STANDBY && cpu_rst_n && power.retain;
  endproperty
  a_standby_resume: assert property (p_standby_resume) else $error("standby wake bad");
  property p_io_frozen;
    mode_q == pms_pkg::MODE_STANDBY ##1 mode_q == pms_pkg::MODE_STANDBY |->
      io_latch && $stable(io_hold);
  endproperty
  a_io_frozen: assert property (p_io_frozen) else $error("pins not frozen");
  property p_shutdown_off;
    mode_q == pms_pkg::MODE_SHUTDOWN |-> power == '0 && io_latch;
  endproperty
  a_shutdown_off: assert property (p_shutdown_off) else $error("shutdown still powered");
  property p_sd_wake;
    mode_q == pms_pkg::MODE_SHUTDOWN && |pin_chg && rst_pin_n_f |=>
      mode_q == pms_pkg::MODE_RESET && cause_q == pms_pkg::CAUSE_SD_WAKE && !cpu_rst_n;
  endproperty
  a_sd_wake: assert property (p_sd_wake) else $error("shutdown pin wake missed");
  property p_pin_reset;
    !rst_pin_n_f |=> mode_q == pms_pkg::MODE_RESET && cnt_q == LD_OFF && !bod_lock_q;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored");
  property p_off_stays;
    mode_q == pms_pkg::MODE_OFF && rst_pin_n_f |=> mode_q == pms_pkg::MODE_OFF;
  endproperty
  a_off_stays: assert property (p_off_stays) else $error("deepest off woke");
  property p_reset_exit;
    mode_q == pms_pkg::MODE_RESET ##1 mode_q == pms_pkg::MODE_ACTIVE |->
      $past(cnt_q) == '0 && cpu_rst_n && !io_latch;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("reset sequence cut");
  property p_bod_lock;
    bod_lock_q && mode_q == pms_pkg::MODE_RESET && rst_pin_n_f |=>
      mode_q == pms_pkg::MODE_RESET;
  endproperty
  a_bod_lock: assert property (p_bod_lock) else $error("lock released early");
  c_idle_wake: cover property (mode_q == pms_pkg::MODE_IDLE ##1 mode_q == pms_pkg::MODE_WAKE);
  c_standby_wake: cover property (mode_q == pms_pkg::MODE_STANDBY
                                  ##1 mode_q == pms_pkg::MODE_WAKE);
  c_sd_wake: cover property (mode_q == pms_pkg::MODE_SHUTDOWN ##1 mode_q == pms_pkg::MODE_RESET);
  c_bod_lock: cover property ($rose(bod_lock_q));
endmodule
`default_nettype wire

// ### verif/pms_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
module pms_osc_model (
  input wire logic pclk,
  output logic slow_xtal_clk,
  output logic slow_rc_clk
);
  logic [3:0] xtal_q = 4'h0;
  logic [4:0] rc_q = 5'h00;
  ////////////////////////////////////////////////////////////////////////////////
  // free-running slow crystal stand-in
  always @(posedge pclk) begin
    xtal_q <= xtal_q + 4'h1;
  end
  // slow rc stand-in, off the crystal rate
  always @(posedge pclk) begin
    rc_q <= (rc_q == 5'h12) ? 5'h00 : rc_q + 5'h01;
  end
  assign slow_xtal_clk = xtal_q[3];
  assign slow_rc_clk = (rc_q > 5'h09);
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int SB = 40;
  localparam int OFF = 80;
  localparam int IDL = pms_pkg::WAKE_IDLE_CYC;
  typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] r; logic e;} pms_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic irq_pending, sensor_wake, recharge, reset_pin_n, brownout, slow_xtal_present, er;
  logic slow_xtal_clk, slow_rc_clk, rtc_capture_pin, cpu_rst_n, brownout_detector_en, io_latch;
  logic [7:0] gpio_level, wake_pin, io_hold;
  pms_pkg::pms_power_s power;
  pms_pkg::pms_clock_s clocks;
  int n_fail = 0;
  int total_checks = 0;
  int n;
  pms_row_s rows [9] = '{'{1'h0, 32'h8, 32'h0, 32'h1, 1'h0}, '{1'h0, 32'h4, 32'h0, 32'h0, 1'h0},
    '{1'h1, 32'hC, 32'hFF, 32'h0, 1'h0}, '{1'h0, 32'hC, 32'h0, 32'hFF, 1'h0},
    '{1'h0, 32'h24, 32'h0, 32'h10000, 1'h0}, '{1'h1, 32'h4, 32'h7, 32'h0, 1'h0},
    '{1'h0, 32'h4, 32'h0, 32'h0, 1'h0}, '{1'h1, 32'h30, 32'h5, 32'h0, 1'h1},
    '{1'h0, 32'h30, 32'h0, 32'h0, 1'h1}};
  ////////////////////////////////////////////////////////////////////////////////
  pms_sequencer #(.NUM_PINS(8), .STANDBY_WAKE_CYC(SB), .OFF_WAKE_CYC(OFF)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_pending(irq_pending), .sensor_wake(sensor_wake), .recharge(recharge),
    .gpio_level(gpio_level), .wake_pin(wake_pin), .reset_pin_n(reset_pin_n),
    .brownout(brownout), .slow_xtal_present(slow_xtal_present), .slow_xtal_clk(slow_xtal_clk),
    .slow_rc_clk(slow_rc_clk), .rtc_capture_pin(rtc_capture_pin), .power(power),
    .clocks(clocks), .cpu_rst_n(cpu_rst_n), .brownout_detector_en(brownout_detector_en),
    .io_latch(io_latch), .io_hold(io_hold));
  pms_osc_model osc (.pclk(pclk), .slow_xtal_clk(slow_xtal_clk), .slow_rc_clk(slow_rc_clk));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // sel 0 waits for cpu clock, 1 for cpu reset release
  task automatic wait_hi(input logic sel);
    n = 0;
    while (((sel ? cpu_rst_n : power.cpu_clk) !== 1'h1) && n < 20000) begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    n_fail++;
    stop_test;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, irq_pending, sensor_wake, recharge, brownout} = 7'h00;
    {paddr, pwdata} = 64'h0;
    {reset_pin_n, slow_xtal_present, rtc_capture_pin} = 3'h6;
    gpio_level = 8'h00;
    wake_pin = 8'h00;
    @(negedge pclk);
    chk("reset power", 32'(power), 32'h1E);
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    wait_hi(1'h1);
    chk("por release", 32'(n >= OFF - 2 && n <= OFF + 3), 32'h1);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("apb error", 32'(er), 32'(rows[i].e));
      if (!rows[i].w) chk("apb data", rd, rows[i].r);
    end
    $display("test registers done");
    apb(1'h1, 32'h0, 32'h18);
    repeat (2) @(negedge pclk);
    chk("doubler", 32'(clocks.doubler_en), 32'h1);
    chk("fast rc", 32'(clocks.fast_src_rc), 32'h1);
    chk("slow src", 32'(clocks.slow_src_rc), 32'h0);
    n = 0;
    while (clocks.slow_clk_out !== 1'h1 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    chk("slow out", 32'(clocks.slow_clk_out), 32'h1);
    apb(1'h1, 32'h0, 32'h0);
    $display("test clocks done");
    apb(1'h1, 32'h0, 32'h1);
    @(negedge pclk);
    chk("idle power", 32'(power), 32'h3E);
    @(posedge pclk);
    irq_pending <= 1'h1;
    wait_hi(1'h0);
    chk("idle wake", 32'(n >= IDL && n <= IDL + 3), 32'h1);
    @(posedge pclk);
    irq_pending <= 1'h0;
    $display("test idle done");
    gpio_level <= 8'hA5;
    apb(1'h1, 32'h0, 32'h2);
    @(negedge pclk);
    chk("standby power", 32'(power), 32'h0D);
    chk("standby latch", 32'(io_latch), 32'h1);
    @(posedge pclk);
    gpio_level <= 8'h5A;
    recharge <= 1'h1;
    irq_pending <= 1'h1;
    repeat (2) @(negedge pclk);
    chk("standby hold", 32'(io_hold), 32'hA5);
    chk("bod recharge", 32'(brownout_detector_en), 32'h1);
    @(posedge pclk);
    recharge <= 1'h0;
    repeat (60) @(negedge pclk);
    chk("bod off", 32'(brownout_detector_en), 32'h0);
    chk("irq ignored", 32'(power.cpu_clk), 32'h0);
    @(posedge pclk);
    irq_pending <= 1'h0;
    sensor_wake <= 1'h1;
    wait_hi(1'h0);
    chk("standby wake", 32'(n >= SB && n <= SB + 3), 32'h1);
    chk("no reset", 32'(cpu_rst_n), 32'h1);
    @(posedge pclk);
    sensor_wake <= 1'h0;
    apb(1'h0, 32'hC, 32'h0);
    chk("mask kept", rd, 32'hFF);
    chk("latch off", 32'(io_latch), 32'h0);
    $display("test standby done");
    gpio_level <= 8'hC3;
    apb(1'h1, 32'h0, 32'h3);
    @(negedge pclk);
    chk("shutdown power", 32'(power), 32'h00);
    chk("shutdown hold", 32'(io_hold), 32'hC3);
    @(posedge pclk);
    wake_pin <= 8'h01;
    repeat (12) @(negedge pclk);
    chk("pin wake reset", 32'(cpu_rst_n), 32'h0);
    wait_hi(1'h1);
    chk("sd wake time", 32'(n <= OFF + 3), 32'h1);
    apb(1'h0, 32'h8, 32'h0);
    chk("cause sd", rd, 32'h4);
    apb(1'h0, 32'hC, 32'h0);
    chk("mask lost", rd, 32'h0);
    $display("test shutdown done");
    apb(1'h1, 32'hC, 32'hFF);
    apb(1'h1, 32'h0, 32'h4);
    @(posedge pclk);
    wake_pin <= 8'h00;
    repeat (150) @(negedge pclk);
    chk("off no pin", 32'(power), 32'h00);
    @(posedge pclk);
    reset_pin_n <= 1'h0;
    repeat (8) @(posedge pclk);
    reset_pin_n <= 1'h1;
    @(negedge pclk);
    chk("pin reset", 32'(cpu_rst_n), 32'h0);
    wait_hi(1'h1);
    apb(1'h0, 32'h8, 32'h0);
    chk("cause pin", rd, 32'h2);
    $display("test off done");
    apb(1'h1, 32'h0, 32'h1);
    apb(1'h1, 32'h24, 32'h20000);
    apb(1'h1, 32'h10, 32'h0);
    apb(1'h1, 32'h14, 32'h4);
    apb(1'h1, 32'h28, 32'h1);
    wait_hi(1'h0);
    chk("rtc wake", 32'(n >= IDL && n <= IDL + 200), 32'h1);
    apb(1'h0, 32'h10, 32'h0);
    chk("rtc step", 32'(rd[0]), 32'h0);
    apb(1'h1, 32'h10, 32'h40);
    rtc_capture_pin <= 1'h1;
    repeat (8) @(posedge pclk);
    rtc_capture_pin <= 1'h0;
    apb(1'h0, 32'h20, 32'h0);
    chk("rtc capture", 32'(rd >= 32'h40 && rd <= 32'h42), 32'h1);
    $display("test rtc done");
    stop_test;
  end
endmodule
`default_nettype wire
